// [dsb_cfg.svh]
/*
  Timing constants for the storage board host controller.
  Assumes a 20 MHz system clock; counts derive from ns figures.
*/
`ifndef DSB_CFG_SVH
`define DSB_CFG_SVH
`define DSB_CLK_NS 50
`define DSB_WORD_W 17
`define DSB_ADDR_W 14
`define DSB_ROW_W 6
`define DSB_ROW_N 64
`define DSB_T_SETUP_NS 24
`define DSB_T_HOLD_NS 50
`define DSB_T_HIGH_NS 260
`define DSB_T_LOW_NS 200
`define DSB_T_CYCLE_NS 460
`define DSB_T_GATE_NS 180
`define DSB_T_SHARE_LO_NS 80
`define DSB_T_SHARE_HI_NS 150
`define DSB_T_ACCESS_NS 320
`define DSB_T_REFRESH_NS 2000000
`define DSB_CEIL(ns) (((ns) + `DSB_CLK_NS - 1) / `DSB_CLK_NS)
`define DSB_N_SETUP `DSB_CEIL(`DSB_T_SETUP_NS)
`define DSB_N_HOLD `DSB_CEIL(`DSB_T_HOLD_NS)
`define DSB_N_HIGH `DSB_CEIL(`DSB_T_HIGH_NS)
`define DSB_N_LOW `DSB_CEIL(`DSB_T_LOW_NS)
// Strobe must outlast both the minimum high time and the access time,
// since the board latches whatever its RAMs show when the strobe falls
`define DSB_N_STROBE \
  ((`DSB_N_ACCESS > `DSB_N_HIGH) ? `DSB_N_ACCESS : `DSB_N_HIGH)
`define DSB_N_GATE_AT (`DSB_N_STROBE - `DSB_CEIL(`DSB_T_GATE_NS))
`define DSB_N_SHARE_UP `DSB_CEIL(`DSB_T_SHARE_LO_NS)
`define DSB_N_ACCESS `DSB_CEIL(`DSB_T_ACCESS_NS)
`define DSB_REF_INTERVAL_NS (`DSB_T_REFRESH_NS / `DSB_ROW_N)
// Slack absorbs a refresh held back behind a cycle already running
`define DSB_T_REF_SLACK_NS 1000
`define DSB_N_REF_INTERVAL \
  ((`DSB_REF_INTERVAL_NS - `DSB_T_REF_SLACK_NS) / `DSB_CLK_NS)
`define DSB_CNT_W 10
`endif

// [dsb_pkg.sv]
/*
  Types for the storage board host controller.
  Assumes dsb_cfg.svh is compiled alongside.
*/
`include "dsb_cfg.svh"
package dsb_pkg;
  typedef enum logic [2:0] {
    DSB_IDLE = 3'b000,
    DSB_SETUP = 3'b001,
    DSB_STROBE = 3'b010,
    DSB_HOLD = 3'b011,
    DSB_RECOVER = 3'b100
  } dsb_state_t;
  typedef enum logic [1:0] {
    DSB_OP_READ = 2'b00,
    DSB_OP_WRITE = 2'b01,
    DSB_OP_REFRESH = 2'b10
  } dsb_op_t;
  // Pins driven toward the board
  typedef struct packed {
    logic cycle_strobe;
    logic read_not_write;
    logic board_select_n;
    logic port_share_n;
    logic output_gate;
    logic refresh_cycle_flag;
    logic [`DSB_ADDR_W-1:0] address;
    logic [`DSB_WORD_W-1:0] write_word_bus;
  } dsb_pins_t;
endpackage

// [dsb_host.sv]
/*
  Host controller driving a 16k x 17 dynamic RAM storage board.
  Assumes board pins are asynchronous to clk_sys; read data is
  synchronised through two flops before capture.
*/
// Contract
// - Cycle starts at least 460 ns apart
// - Active-high strobe starts every cycle
// - Strobe high 260 ns, low 200 ns
// - Read_not_write low read, held past strobe
// - Board select low 24 ns before, after
// - Read: port share low around strobe
// - Write: port share low, then raised early
// - Refresh: port share high around leading edge
// - Read: gate high 180 ns before fall
// - Output gate low in write, refresh
// - Refresh flag high around refresh strobe
// - Refresh all 64 rows within 2 ms
// - Write data stable 150/50 ns around fall
`timescale 1ns/1ns
`include "dsb_cfg.svh"
module dsb_host #(
  parameter int unsigned REF_INTERVAL = `DSB_N_REF_INTERVAL
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // User request port
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [`DSB_ADDR_W-1:0] req_addr,
  input wire logic [`DSB_WORD_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [`DSB_WORD_W-1:0] rsp_rdata,
  // Board pins
  output dsb_pkg::dsb_pins_t pins,
  input wire logic [`DSB_WORD_W-1:0] read_word_bus
);
  // Counts in clk_sys periods, rounded up so no minimum is cut short
  localparam logic [`DSB_CNT_W-1:0] N_SETUP = `DSB_CNT_W'(`DSB_N_SETUP);
  localparam logic [`DSB_CNT_W-1:0] N_HOLD = `DSB_CNT_W'(`DSB_N_HOLD);
  // Strobe high time also covers the read access, as the board latches
  // whatever it has at the fall; RECOVER still ends at N_LOW, as N_ACC - N_HIGH is zero, so a transfer takes one cycle longer
  localparam logic [`DSB_CNT_W-1:0] N_HIGH = `DSB_CNT_W'(`DSB_N_STROBE);
  localparam logic [`DSB_CNT_W-1:0] N_LOW = `DSB_CNT_W'(`DSB_N_LOW);
  localparam logic [`DSB_CNT_W-1:0] N_GATE = `DSB_CNT_W'(`DSB_N_GATE_AT);
  localparam logic [`DSB_CNT_W-1:0] N_SHUP = `DSB_CNT_W'(`DSB_N_SHARE_UP);
  localparam logic [`DSB_CNT_W-1:0] N_ACC = `DSB_CNT_W'(`DSB_N_ACCESS);

  // Sequencer, refresh and answer state
  dsb_pkg::dsb_state_t state_r, state_nxt;
  dsb_pkg::dsb_op_t op_r, op_nxt;
  dsb_pkg::dsb_pins_t pins_r, pins_nxt;
  logic [`DSB_CNT_W-1:0] cnt_r, cnt_nxt;
  logic [31:0] ref_cnt_r, ref_cnt_nxt;
  logic ref_pend_r, ref_pend_nxt;
  logic [`DSB_ROW_W-1:0] ref_row_r, ref_row_nxt;
  logic [`DSB_WORD_W-1:0] din_s1_r, din_s2_r;
  logic [`DSB_WORD_W-1:0] rdata_r, rdata_nxt;
  logic rsp_r, rsp_nxt, ready_r, ready_nxt;

  // Read decode shared by gate and capture logic
  function automatic logic is_read(input dsb_pkg::dsb_op_t op);
    return op == dsb_pkg::DSB_OP_READ;
  endfunction

  // Two-flop synchroniser on the board's read bus
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      din_s1_r <= '0;
      din_s2_r <= '0;
    end else begin
      din_s1_r <= read_word_bus;
      din_s2_r <= din_s1_r;
    end
  end

  // Refresh timer: one row every 2 ms / 64, row wraps over 64 rows.
  // Interval is trimmed so a refresh held back behind a running cycle
  // still lands inside the row period
  always_comb begin
    ref_cnt_nxt = ref_cnt_r + 32'h1;
    ref_pend_nxt = ref_pend_r;
    ref_row_nxt = ref_row_r;
    if (ref_cnt_r >= REF_INTERVAL - 1) begin
      ref_cnt_nxt = 32'h0;
      ref_pend_nxt = 1'b1;
    end
    // Issue and new tick together keep the request pending
    if (state_r == dsb_pkg::DSB_IDLE && ref_pend_r &&
        ref_cnt_r < REF_INTERVAL - 1) begin
      ref_pend_nxt = 1'b0;
      ref_row_nxt = ref_row_r + `DSB_ROW_W'(1);
    end
  end

  // Cycle sequencer; refresh beats user requests so rows never lapse
  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    pins_nxt = pins_r;
    cnt_nxt = cnt_r + `DSB_CNT_W'(1);
    rdata_nxt = rdata_r;
    rsp_nxt = 1'b0;
    ready_nxt = 1'b0;
    case (state_r)
      dsb_pkg::DSB_IDLE: begin
        cnt_nxt = '0;
        pins_nxt.board_select_n = 1'b1;
        pins_nxt.refresh_cycle_flag = 1'b0;
        pins_nxt.output_gate = 1'b0;
        pins_nxt.port_share_n = 1'b1;
        if (ref_pend_r) begin
          op_nxt = dsb_pkg::DSB_OP_REFRESH;
          // Select stays high: the board ignores it during refresh
          pins_nxt.refresh_cycle_flag = 1'b1;
          pins_nxt.port_share_n = 1'b1;
          pins_nxt.address = {`DSB_ADDR_W'(0) | `DSB_ADDR_W'(ref_row_r)};
          state_nxt = dsb_pkg::DSB_SETUP;
        end else if (req_valid && ready_r) begin
          op_nxt = req_write ? dsb_pkg::DSB_OP_WRITE : dsb_pkg::DSB_OP_READ;
          pins_nxt.read_not_write = req_write;
          pins_nxt.board_select_n = 1'b0;
          pins_nxt.port_share_n = 1'b0;
          pins_nxt.address = req_addr;
          pins_nxt.write_word_bus = req_wdata;
          state_nxt = dsb_pkg::DSB_SETUP;
        end else begin
          // Ready only when no refresh is due at the next edge, so a
          // request seen with ready high is never passed over
          ready_nxt = !ref_pend_nxt;
        end
      end
      dsb_pkg::DSB_SETUP: begin
        // Controls settle one full cycle (50 ns) before strobe rises
        // A finer clock could trim this, at the cost of more counts
        if (cnt_r >= N_SETUP - `DSB_CNT_W'(1)) begin
          pins_nxt.cycle_strobe = 1'b1;
          cnt_nxt = '0;
          state_nxt = dsb_pkg::DSB_STROBE;
        end
      end
      dsb_pkg::DSB_STROBE: begin
        // Write: release port share after low time, well before fall
        if (op_r == dsb_pkg::DSB_OP_WRITE &&
            cnt_r == N_SHUP - `DSB_CNT_W'(1))
          pins_nxt.port_share_n = 1'b1;
        // Read only: gate opens four cycles (200 ns) ahead of the fall, covering the 180 ns
        if (is_read(op_r) && cnt_r == N_GATE - `DSB_CNT_W'(1))
          pins_nxt.output_gate = 1'b1;
        if (cnt_r == N_HIGH - `DSB_CNT_W'(1)) begin
          pins_nxt.cycle_strobe = 1'b0;
          cnt_nxt = '0;
          state_nxt = dsb_pkg::DSB_HOLD;
        end
      end
      dsb_pkg::DSB_HOLD: begin
        // Sample synchronised data; board holds it while gate stays up.
        // The word stood on the bus at the fall, so two flops later the
        // synchroniser output is settled and matches the latch
        if (is_read(op_r) && cnt_r == `DSB_CNT_W'(1)) begin
          rdata_nxt = din_s2_r;
          rsp_nxt = 1'b1;
        end
        if (cnt_r == N_HOLD) begin
          pins_nxt.board_select_n = 1'b1;
          pins_nxt.output_gate = 1'b0;
          pins_nxt.port_share_n = 1'b1;
          pins_nxt.refresh_cycle_flag = 1'b0;
          state_nxt = dsb_pkg::DSB_RECOVER;
        end
      end
      dsb_pkg::DSB_RECOVER: begin
        // Low time plus hold covers the 460 ns cycle floor
        // Ready returns one cycle after this, from IDLE
        if (cnt_r >= N_LOW + N_ACC - N_HIGH) begin
          state_nxt = dsb_pkg::DSB_IDLE;
        end
      end
      default: state_nxt = dsb_pkg::DSB_IDLE;
    endcase
  end

  // State registers; reset leaves every pin at its idle level
  // so the board sees no cycle while the host is held
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= dsb_pkg::DSB_IDLE;
      op_r <= dsb_pkg::DSB_OP_READ;
      pins_r <= '{board_select_n: 1'b1, port_share_n: 1'b1, default: '0};
      cnt_r <= '0;
      ref_cnt_r <= '0;
      ref_pend_r <= 1'b0;
      ref_row_r <= '0;
      rdata_r <= '0;
      rsp_r <= 1'b0;
      ready_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      pins_r <= pins_nxt;
      cnt_r <= cnt_nxt;
      ref_cnt_r <= ref_cnt_nxt;
      ref_pend_r <= ref_pend_nxt;
      ref_row_r <= ref_row_nxt;
      rdata_r <= rdata_nxt;
      rsp_r <= rsp_nxt;
      ready_r <= ready_nxt;
    end
  end

  // Every output is a register; nothing combinational reaches a pin
  assign pins = pins_r;
  assign rsp_valid = rsp_r;
  assign rsp_rdata = rdata_r;
  assign req_ready = ready_r;
endmodule

// [dsb_host_properties.sv]
/* Pin timing checks for the storage board host controller.
   Assumes it is bound onto dsb_host and sees only its ports. */
`timescale 1ns/1ns
module dsb_host_properties #(
  parameter int unsigned REF_INTERVAL = 605
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Board pins
  input dsb_pkg::dsb_pins_t pins
);
  logic s;
  logic w;
  logic f;
  // Short aliases keep the properties readable
  assign s = pins.cycle_strobe;
  assign w = pins.read_not_write;
  assign f = pins.refresh_cycle_flag;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  property p_high;
    $rose(s) |-> s[*6];
  endproperty
  a_high: assert property (p_high) else $error("strobe high short");
  property p_low;
    $fell(s) |-> (!s)[*4];
  endproperty
  a_low: assert property (p_low) else $error("strobe low short");
  property p_sel;
    (s || $fell(s)) && !f |-> !$past(pins.board_select_n) && !pins.board_select_n;
  endproperty
  a_sel: assert property (p_sel) else $error("select window");
  property p_ctl;
    s || $fell(s) |-> $stable({w, f, pins.address});
  endproperty
  a_ctl: assert property (p_ctl) else $error("control moved");
  property p_rd_share;
    (s || $fell(s)) && !w && !f |-> !pins.port_share_n;
  endproperty
  a_rd_share: assert property (p_rd_share) else $error("read share");
  property p_wr_share;
    $rose(s) && w && !f |->
      (!pins.port_share_n)[*2] ##1 (s && pins.port_share_n)[*4];
  endproperty
  a_wr_share: assert property (p_wr_share) else $error("write share");
  property p_gate;
    $rose(s) && !w && !f |-> ##3 pins.output_gate[*5];
  endproperty
  a_gate: assert property (p_gate) else $error("gate late");
  property p_glead;
    $fell(s) && !w && !f |-> $past(pins.output_gate, 4);
  endproperty
  a_glead: assert property (p_glead) else $error("gate lead");
  property p_rshare;
    $rose(s) && f |-> ($past(f) && pins.port_share_n) ##1 pins.port_share_n;
  endproperty
  a_rshare: assert property (p_rshare)
    else $error("refresh share");
  property p_nogate;
    (s || $fell(s)) && (w || f) |-> !pins.output_gate;
  endproperty
  a_nogate: assert property (p_nogate) else $error("gate high");
endmodule

// [dsb_board.sv]
/* Behavioural storage board answering dsb_host.
   Assumes its pins come straight from the host controller. */
`timescale 1ns/1ns
module dsb_board (
  // Host pins and answer pace
  input dsb_pkg::dsb_pins_t pins,
  input wire logic slow,
  // Read word toward the host
  output logic [16:0] read_word_bus
);
  logic [16:0] mem [4][4096]; // Four rows of 4k words
  logic [16:0] ram_q = '0;
  logic [16:0] lat_q = '0;
  logic drive = 1'b0;
  bit [63:0] seen = '0;
  // Strobe opens a cycle; top bits pick the row
  always @(posedge pins.cycle_strobe) begin
    if (pins.refresh_cycle_flag)
      seen[pins.address[5:0]] = 1'b1;
    else if (!pins.read_not_write) begin
      ram_q = ~lat_q;
      #(slow ? 320 : 90);
      ram_q = mem[pins.address[13:12]][pins.address[11:0]];
    end
  end
  // Writes land and reads latch on the trailing edge
  always @(negedge pins.cycle_strobe) begin
    if (!pins.refresh_cycle_flag && !pins.board_select_n) begin
      if (pins.read_not_write)
        mem[pins.address[13:12]][pins.address[11:0]] = pins.write_word_bus;
      else
        lat_q = ram_q;
    end
  end
  // Bus stays driven briefly after gate or select drop
  always @(pins.output_gate or pins.board_select_n) begin
    if (pins.output_gate && !pins.board_select_n)
      drive = 1'b1;
    else
      drive <= #10 1'b0;
  end
  // Floating bus shows the inverse word, never a stale match
  assign read_word_bus = !drive ? ~lat_q :
    (pins.cycle_strobe ? ram_q : lat_q);
endmodule

// [testbench.sv]
/* Self-checking bench for dsb_host against a board model.
   Assumes the package, checker and board model are compiled first. */
`timescale 1ns/1ns
module testbench;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [13:0] req_addr = '0;
  logic [16:0] req_wdata = '0;
  logic slow = 1'b0;
  logic req_ready;
  logic rsp_valid;
  logic [16:0] rsp_rdata;
  logic [16:0] read_word_bus;
  logic [16:0] idle_seen;
  dsb_pkg::dsb_pins_t pins;
  logic [16:0] shadow [logic [13:0]];
  logic [13:0] used [$];
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  // 20 MHz system clock
  always #25 clk_sys = ~clk_sys;
  dsb_host #(.REF_INTERVAL(50)) u_dsb_host (.clk_sys(clk_sys),
    .rst_b(rst_b), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .pins(pins),
    .read_word_bus(read_word_bus));
  dsb_board u_dsb_board (.pins(pins), .slow(slow),
    .read_word_bus(read_word_bus));
  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Idle pins: ready, strobe, select_n, share_n, gate, flag
  function automatic logic [16:0] idle_pins(input logic rdy);
    return {11'h000, rdy, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  endfunction
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // One request, held until taken; reads compared on answer
  task automatic access(input logic wr, input logic [13:0] a,
                        input logic [16:0] d);
    @(negedge clk_sys);
    while (req_ready !== 1'b1) @(negedge clk_sys);
    slow = 1'($urandom_range(1));
    {req_valid, req_write, req_addr, req_wdata} = {1'b1, wr, a, d};
    @(negedge clk_sys);
    req_valid = 1'b0;
    if (wr) begin
      shadow[a] = d;
      used.push_back(a);
    end else begin
      while (rsp_valid !== 1'b1) @(negedge clk_sys);
      check(rsp_rdata, shadow[a]);
    end
  endtask
  // Hang guard, well above the expected run length
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    void'($urandom(32'h6DCA3B9E));
    repeat (12) @(negedge clk_sys);
    rst_b = 1'b1;
    // First and last column of every row, then read back
    for (int i = 0; i < 16; i++)
      access(i < 8, {i[2:1], {12{i[0]}}}, {i[0], 2'b10, i[2:1], {12{i[0]}}});
    for (int i = 0; i < 200; i++) begin
      if ($urandom_range(1))
        access(1'b1, 14'($urandom), 17'($urandom));
      else
        access(1'b0, used[$urandom_range(used.size() - 1)], '0);
    end
    // Reset in mid read: pins go idle and stored data survives
    @(negedge clk_sys);
    while (req_ready !== 1'b1) @(negedge clk_sys);
    {req_valid, req_write, req_addr} = {1'b1, 1'b0, used[0]};
    @(negedge clk_sys);
    req_valid = 1'b0;
    repeat (4) @(negedge clk_sys);
    rst_b = 1'b0;
    @(negedge clk_sys);
    idle_seen = {11'h000, req_ready, pins.cycle_strobe, pins.board_select_n,
      pins.port_share_n, pins.output_gate, pins.refresh_cycle_flag};
    check(idle_seen, idle_pins(1'b0));
    rst_b = 1'b1;
    access(1'b0, used[0], '0);
    // Idle long enough for 64 refresh intervals of 50 cycles
    repeat (3400) @(negedge clk_sys);
    check({16'h0000, &u_dsb_board.seen}, 17'h00001);
    tally_and_finish();
  end
endmodule
bind dsb_host dsb_host_properties #(.REF_INTERVAL(REF_INTERVAL)) u_props (
  .clk_sys(clk_sys), .rst_b(rst_b), .pins(pins));
